// File: wdt_params.svh
/*
  Constants of the watchdog: register locations, option bit positions,
  counter widths and timing counts.
  Assumes inclusion by bare name from the watchdog package and module.
*/
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

`define WDT_OPT_ADDR        16'h001f
`define WDT_SVC_ADDR        16'hffff
`define WDT_RSTVEC_HI_ADDR  16'hfffe
`define WDT_OPT_RATE_BIT    2
`define WDT_OPT_STOPEN_BIT  1
`define WDT_OPT_DIS_BIT     0
`define WDT_PRE_W           12
`define WDT_CNT_W           6
`define WDT_PRE_KEEP_W      4
`define WDT_RATE_LONG_TAP   11
`define WDT_RATE_SHORT_TAP  6
`define WDT_RST_PULSE_CYC   32
`define WDT_RST_PULSE_W     6
`define WDT_POR_DELAY_CYC   4096
`define WDT_POR_DELAY_W     13

`endif

// File: wdt_pkg.sv
/*
  Types shared by the watchdog: register bus request and mode inputs.
  Assumes wdt_params.svh is on the include path.
*/
`include "wdt_params.svh"

package wdt_pkg;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } wdt_bus_s;

  typedef struct packed {
    logic mon_test_voltage_entry;
    logic mon_blank_entry;
    logic test_voltage_irq;
    logic test_voltage_rst;
    logic break_active;
    logic stop_exec;
    logic wait_mode;
    logic vec_fetch;
  } wdt_mode_s;

  typedef enum logic [2:0] {
    WDT_RUN   = 3'b001,
    WDT_PULSE = 3'b010,
    WDT_STOP  = 3'b100
  } wdt_state_e;

endpackage

// File: wdt_watchdog.sv
/*
  Watchdog timer: prescaler plus 6-bit counter; overflow drives the reset pin
  low and flags a watchdog reset. Serviced by any write to the service location.
  Assumes core_clk is the crystal clock, inputs are synchronous to it, and
  rst_b is the internal reset (power-on or any other source).
*/
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "wdt_params.svh"

// Operation
// - Six-bit counter advanced by twelve-bit prescaler, both on crystal clock.
// - Unserviced counter overflow raises a system reset.
// - Rate bit one gives 2^18-2^4 cycles, zero gives 2^13-2^4.
// - Any write to service location clears counter and prescaler bits 11..4.
// - Reading service location returns reset vector low byte.
// - Watchdog reset drives reset pin low 32 cycles, sets flag.
// - Stop instruction clears the prescaler.
// - Prescaler cleared 4096 cycles after power-up.
// - Internal reset clears prescaler and counter.
// - Reset vector fetch clears the prescaler.
// - Disable option bit one turns the watchdog off.
// - Monitor entry with test voltage disables while voltage stays on pins.
// - Monitor entry by blank vectors disables until next power-on reset.
// - Counting continues during wait mode.
// - Stop mode gates the clock to the watchdog and clears prescaler.
// - Stop-disable option turns stop into an illegal-opcode reset.
// - Break with test voltage on reset pin disables the watchdog.
// - No interrupt requests; timeout only resets.
module wdt_watchdog #(
  parameter logic [7:0] OPTION_VALUE  = 8'h00,  // Option register contents
  parameter logic [7:0] RST_VEC_LO    = 8'h00,  // Reset vector low byte
  parameter int         POR_DELAY_CYC = `WDT_POR_DELAY_CYC  // Power-up clear delay
) (
  input  wire logic              core_clk,      // Crystal clock
  input  wire logic              rst_b,         // Internal reset, active low
  input  wire logic              por_b,         // Power-on reset, active low
  input  wire wdt_pkg::wdt_bus_s bus,           // Register bus request
  output logic [7:0]             rdata,         // Read data, cycle after read
  input  wire wdt_pkg::wdt_mode_s mode,         // CPU mode inputs
  output logic                   rst_pin_o,     // Reset pin drive value
  output logic                   rst_pin_oe,    // Reset pin output enable
  output logic                   wdt_flag,      // Watchdog reset flag
  output logic                   illegal_rst,   // Illegal-opcode reset pulse
  output logic                   stopped,       // Stop mode entered
  output logic                   irq            // Interrupt, never raised
);

  localparam int PW = `WDT_PRE_W;
  localparam int CW = `WDT_CNT_W;

  logic [PW-1:0]               pre_q;
  logic [CW-1:0]               cnt_q;
  logic [`WDT_RST_PULSE_W-1:0] pulse_q;
  logic [`WDT_POR_DELAY_W-1:0] por_cnt_q;
  logic                        por_done_q;
  logic                        blank_dis_q;
  logic                        test_voltage_dis_q;
  logic                        flag_q;
  logic                        ill_q;
  logic [7:0]                  rdata_q;
  wdt_pkg::wdt_state_e         state_q;

  // Option bits are strapped: read-only and untouched by reset
  wire opt_rate   = OPTION_VALUE[`WDT_OPT_RATE_BIT];
  wire opt_nostop = OPTION_VALUE[`WDT_OPT_STOPEN_BIT];
  wire opt_dis    = OPTION_VALUE[`WDT_OPT_DIS_BIT];

  wire svc_wr  = bus.wr && (bus.addr == `WDT_SVC_ADDR);
  wire opt_rd  = bus.rd && (bus.addr == `WDT_OPT_ADDR);
  wire svc_rd  = bus.rd && (bus.addr == `WDT_SVC_ADDR);
  wire test_voltage_on = mode.test_voltage_irq || mode.test_voltage_rst;

  wire disabled = opt_dis
               || (test_voltage_dis_q && test_voltage_on)
               || blank_dis_q
               || (mode.break_active && mode.test_voltage_rst);

  wire run       = (state_q == wdt_pkg::WDT_RUN);
  // Wait mode is deliberately not a gating term
  wire counting  = run && !disabled;
  wire stop_go   = run && mode.stop_exec && !opt_nostop;
  wire stop_bad  = run && mode.stop_exec && opt_nostop;
  wire pre_clr   = stop_go || mode.vec_fetch
                || (por_cnt_q == `WDT_POR_DELAY_W'(POR_DELAY_CYC - 1) && !por_done_q);
  wire tap_bit   = opt_rate ? pre_q[`WDT_RATE_LONG_TAP]
                            : pre_q[`WDT_RATE_SHORT_TAP];
  logic tap_q;
  wire  tick     = tap_q && !tap_bit;
  wire  overflow = counting && tick && (&cnt_q) && !svc_wr;

  logic [PW-1:0] pre_d;
  always_comb begin
    pre_d = counting ? PW'(pre_q + 1'b1) : pre_q;
    if (pre_clr || !run) begin
      pre_d = '0;
    end else if (svc_wr) begin
      pre_d = {{(PW-`WDT_PRE_KEEP_W){1'b0}}, pre_q[`WDT_PRE_KEEP_W-1:0]};
    end
  end

  // Power-up delay counter keeps running on por_b only
  always_ff @(posedge core_clk or negedge por_b) begin
    if (!por_b) begin
      por_cnt_q   <= '0;
      por_done_q  <= 1'b0;
      blank_dis_q <= 1'b0;
    end else begin
      if (!por_done_q) begin
        por_cnt_q  <= `WDT_POR_DELAY_W'(por_cnt_q + 1'b1);
        por_done_q <= (por_cnt_q == `WDT_POR_DELAY_W'(POR_DELAY_CYC - 1));
      end
      if (mode.mon_blank_entry && !mode.test_voltage_irq) begin
        blank_dis_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_q      <= '0;
      cnt_q      <= '0;
      tap_q      <= 1'b0;
      pulse_q    <= '0;
      flag_q     <= 1'b0;
      ill_q      <= 1'b0;
      rdata_q    <= 8'h00;
      test_voltage_dis_q <= 1'b0;
      state_q    <= wdt_pkg::WDT_RUN;
    end else begin
      pre_q   <= pre_d;
      tap_q   <= (pre_clr || svc_wr || !run) ? 1'b0 : tap_bit;
      ill_q   <= stop_bad;
      rdata_q <= svc_rd ? RST_VEC_LO
               : opt_rd ? OPTION_VALUE : 8'h00;
      if (mode.mon_test_voltage_entry && mode.test_voltage_irq) begin
        test_voltage_dis_q <= 1'b1;
      end else if (!test_voltage_on) begin
        test_voltage_dis_q <= 1'b0;
      end
      if (overflow) begin
        flag_q <= 1'b1;
      end
      unique case (state_q)
        wdt_pkg::WDT_RUN: begin
          if (svc_wr) begin
            cnt_q <= '0;
          end else if (counting && tick) begin
            cnt_q <= CW'(cnt_q + 1'b1);
          end
          if (overflow) begin
            pulse_q <= `WDT_RST_PULSE_W'(`WDT_RST_PULSE_CYC - 1);
            state_q <= wdt_pkg::WDT_PULSE;
          end else if (stop_go) begin
            state_q <= wdt_pkg::WDT_STOP;
          end
        end
        wdt_pkg::WDT_PULSE: begin
          cnt_q <= '0;
          if (pulse_q == '0) begin
            state_q <= wdt_pkg::WDT_RUN;
          end else begin
            pulse_q <= `WDT_RST_PULSE_W'(pulse_q - 1'b1);
          end
        end
        wdt_pkg::WDT_STOP: begin
          // Clock gated: hold the counter, leave when stop_exec drops or on reset
          if (!mode.stop_exec) begin
            state_q <= wdt_pkg::WDT_RUN;
          end
        end
      endcase
    end
  end

  assign rdata       = rdata_q;
  assign rst_pin_o   = 1'b0;
  assign rst_pin_oe  = (state_q == wdt_pkg::WDT_PULSE);
  assign wdt_flag    = flag_q;
  assign illegal_rst = ill_q;
  assign stopped     = (state_q == wdt_pkg::WDT_STOP);
  assign irq         = 1'b0;

endmodule // wdt_watchdog

// File: wdt_props.sv
/* Watchdog checker: reads, timeout floor, reset pulse, flag, stop.
   Assumes binding onto wdt_watchdog, whose ports it watches. */
`timescale 1ns/1ps
module wdt_props #(
  parameter logic [7:0] OPTION_VALUE = 8'h00,  // Option contents
  parameter logic [7:0] RST_VEC_LO   = 8'h00   // Vector low byte
) (
  input wire logic               core_clk,     // Clock
  input wire logic               rst_b,        // Reset, active low
  input wire logic               por_b,        // Power-on reset
  input wire wdt_pkg::wdt_bus_s  bus,          // Bus request
  input wire logic [7:0]         rdata,        // Read data
  input wire wdt_pkg::wdt_mode_s mode,         // Mode inputs
  input wire logic               rst_pin_o,    // Pin value
  input wire logic               rst_pin_oe,   // Pin enable
  input wire logic               wdt_flag,     // Reset flag
  input wire logic               illegal_rst,  // Illegal-opcode reset
  input wire logic               stopped,      // Stop state
  input wire logic               irq           // Interrupt
);
  localparam int TMO = OPTION_VALUE[2] ? 262128 : 8176;
  logic [5:0]  pul_q;
  logic [18:0] gap_q;
  wire svc = bus.wr && bus.addr == 16'hffff;
  // Gap restarts at each overflow too, so a second timeout is judged alone
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pul_q <= 6'h00;
      gap_q <= 19'h00000;
    end else begin
      pul_q <= rst_pin_oe ? pul_q + 6'h01 : 6'h00;
      gap_q <= (svc || (rst_pin_oe && pul_q == 6'h00)) ? 19'h00000 : gap_q + 19'(gap_q != '1);
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_irq_quiet: assert property (irq == 1'b0) else $error("irq raised");
  a_pin_low: assert property (rst_pin_oe |-> rst_pin_o == 1'b0) else $error("pin not low");
  a_vec_read: assert property (bus.rd && bus.addr == 16'hffff |=> rdata == RST_VEC_LO) else $error("bad vector read");
  a_opt_read: assert property (bus.rd && bus.addr == 16'h001f |=> rdata == OPTION_VALUE) else $error("bad option read");
  a_pulse_len: assert property ($fell(rst_pin_oe) |-> pul_q == 6'h20) else $error("pulse length wrong");
  a_flag_set: assert property ($rose(rst_pin_oe) |-> ##[0:2] wdt_flag) else $error("flag not set");
  a_flag_keep: assert property (wdt_flag |=> wdt_flag) else $error("flag dropped");
  a_tmo_floor: assert property ($rose(rst_pin_oe) |-> gap_q >= TMO) else $error("timeout too early");
  a_stop_enter: assert property (mode.stop_exec && !OPTION_VALUE[1] |-> ##[0:2] stopped) else $error("stop not entered");
  a_stop_quiet: assert property (stopped |-> !$rose(rst_pin_oe)) else $error("reset while stopped");
  a_no_illegal: assert property (!OPTION_VALUE[1] |-> !illegal_rst) else $error("spurious illegal reset");
endmodule // wdt_props
bind wdt_watchdog wdt_props #(.OPTION_VALUE(OPTION_VALUE), .RST_VEC_LO(RST_VEC_LO)) u_props (
  .core_clk(core_clk), .rst_b(rst_b), .por_b(por_b), .bus(bus), .rdata(rdata), .mode(mode),
  .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .wdt_flag(wdt_flag),
  .illegal_rst(illegal_rst), .stopped(stopped), .irq(irq));

// File: wdt_cpu.sv
/* CPU model: bus master issuing one-cycle reads and writes.
   Assumes read data stand in the cycle after the read strobe. */
`timescale 1ns/1ps
module wdt_cpu (
  input  wire logic        core_clk,  // Clock
  input  wire logic [7:0]  rdata,     // Read data
  output wdt_pkg::wdt_bus_s bus       // Bus request
);
  initial bus = '0;
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule // wdt_cpu

// File: tb.sv
/* Watchdog testbench: reads, service, timeout, pulse, stop, disables.
   Assumes short rate option and a shortened power-up delay. */
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] OPT = 8'ha0;
  localparam logic [7:0] VEC = 8'h5c;
  localparam int LO = 8174;  // Service lands an edge before counting starts
  localparam int HI = 8193;
  logic core_clk, rst_b, por_b, oe, flag;
  logic [7:0] rdata, d;
  wdt_pkg::wdt_bus_s bus;
  wdt_pkg::wdt_mode_s mode;
  int n_errors = 0, cmp_count = 0, cyc = 0, lfsr = 65994, k, i;
  logic [15:0] ad[3] = '{16'hffff, 16'h001f, 16'h0010};
  logic [7:0] ex[3] = '{VEC, OPT, 8'h00};
  localparam int POR = 16;  // Shortened power-up delay; its prescaler clear adds this much
  wdt_cpu u_cpu (.core_clk(core_clk), .rdata(rdata), .bus(bus));
  wdt_watchdog #(.OPTION_VALUE(OPT), .RST_VEC_LO(VEC), .POR_DELAY_CYC(POR)) uut (
    .core_clk(core_clk), .rst_b(rst_b), .por_b(por_b), .bus(bus), .rdata(rdata), .mode(mode),
    .rst_pin_o(), .rst_pin_oe(oe), .wdt_flag(flag), .illegal_rst(), .stopped(), .irq());
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic rst(input logic p);
    @(posedge core_clk);
    rst_b <= 1'b0;
    por_b <= ~p;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    por_b <= 1'b1;
  endtask
  task automatic run(input int n);
    k = 0;
    while (k < n && oe !== 1'b1) begin
      @(posedge core_clk);
      #1 k++;
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 95000) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    rst_b = 1'b0;
    por_b = 1'b0;
    mode = '0;
    rst(1'b1);
    for (i = 0; i < 3; i++) begin
      u_cpu.wr(ad[i], 8'hff);
      u_cpu.rd(ad[i], d);
      chk("rdata", d, ex[i]);
    end
    mode.wait_mode <= 1'b1;
    for (i = 0; i < 4; i++) begin
      lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
      repeat (lfsr % 4000) @(posedge core_clk);
      chk("no_reset", oe, 0);
      u_cpu.wr(16'hffff, lfsr[7:0]);
    end
    run(9000);
    chk("timeout", k >= LO && k <= HI, 1);
    run(0);
    k = 0;
    while (oe === 1'b1 && k < 99) begin
      @(posedge core_clk);
      #1 k++;
    end
    chk("pulse", k, 32);
    chk("flag", flag, 1);
    mode.wait_mode <= 1'b0;
    rst(1'b1);
    #1 chk("flag_clr", flag, 0);
    mode.stop_exec <= 1'b1;
    run(9000);
    chk("stop", k, 9000);
    mode.stop_exec <= 1'b0;
    u_cpu.wr(16'hffff, 8'h00);
    run(9000);
    chk("tmo_stop", k >= LO && k <= HI, 1);
    for (i = 0; i < 3; i++) begin
      rst(1'b1);
      mode <= '{mon_test_voltage_entry: i == 0, test_voltage_irq: i == 0, break_active: i == 1,
                test_voltage_rst: i == 1, mon_blank_entry: i == 2, default: 1'b0};
      @(posedge core_clk);
      mode.mon_test_voltage_entry <= 1'b0;
      mode.mon_blank_entry <= 1'b0;
      if (i == 2) rst(1'b0);
      run(9000);
      chk("disabled", k, 9000);
      mode <= '0;
    end
    rst(1'b1);
    run(9000);
    chk("tmo_por", k >= LO + POR && k <= HI + POR, 1);
    end_sim();
  end
endmodule // tb
